// [ptd_pkg.sv]
// package for the pulse/tap detector: register map, field positions, reset values, timing
// assumes a single 40 MHz clock domain and byte-wide register access
package ptd_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] PTD_CFG_ADDR = 8'h21;
    localparam logic [7:0] PTD_STAT_ADDR = 8'h22;
    localparam logic [7:0] PTD_THX_ADDR = 8'h23;
    localparam logic [7:0] PTD_THY_ADDR = 8'h24;
    localparam logic [7:0] PTD_THZ_ADDR = 8'h25;
    localparam logic [7:0] PTD_TMLT_ADDR = 8'h26;
    localparam logic [7:0] PTD_LTCY_ADDR = 8'h27;
    localparam logic [7:0] PTD_WIND_ADDR = 8'h28;
    localparam logic [7:0] PTD_MODE_ADDR = 8'h29;
    localparam logic [7:0] PTD_IRQ_STAT_ADDR = 8'h2a;
    localparam logic [7:0] PTD_IRQ_CLR_ADDR = 8'h2b;
    localparam logic [7:0] PTD_IRQ_EN_ADDR = 8'h2c;
    // config fields
    localparam int PTD_CFG_SPE_X = 0;
    localparam int PTD_CFG_ABORT = 7;
    localparam int PTD_CFG_LATCH = 6;
    // status fields
    localparam int PTD_ST_POL_LSB = 0;
    localparam int PTD_ST_DPE = 3;
    localparam int PTD_ST_AX_LSB = 4;
    localparam int PTD_ST_EA = 7;
    // mode register fields
    localparam int PTD_MODE_HPF = 0;
    localparam int PTD_MODE_OSR_LSB = 1;
    localparam int PTD_MODE_ODR_LSB = 3;
    localparam int PTD_MODE_FS_LSB = 6;
    // reset values
    localparam logic [7:0] PTD_REG_RST = 8'h00;
    // timing: finest detection time step, in ns, and its clock count at 40 MHz
    localparam int PTD_CLK_NS = 25;
    localparam int PTD_STEP_NS = 625000;
    localparam int PTD_STEP_CYC = PTD_STEP_NS / PTD_CLK_NS;
    localparam int PTD_TMLT_MAX = 255;
    // 7-bit threshold at 63 mg per count on an 8 g basis; samples are 14-bit at 1 mg/count
    localparam int PTD_THS_MG = 63;
    typedef enum logic [1:0] {
        PTD_IDLE = 2'b00,
        PTD_HIGH = 2'b01,
        PTD_LTCY = 2'b11,
        PTD_WIND = 2'b10
    } ptd_state_t;
endpackage

// [ptd_axis_if.sv]
// bundle between the top and one axis detector
// assumes the top drives the configuration and the step pulse
`timescale 1ns/100ps
interface ptd_axis_if;
    logic step;
    logic [13:0] mag;
    logic neg;
    logic [6:0] ths;
    logic [7:0] tmlt;
    logic [7:0] ltcy;
    logic [7:0] wind;
    logic abort;
    logic single_ev;
    logic double_ev;
    logic ev_neg;
    modport top (output step, mag, neg, ths, tmlt, ltcy, wind, abort,
                 input single_ev, double_ev, ev_neg);
    modport axis (input step, mag, neg, ths, tmlt, ltcy, wind, abort,
                  output single_ev, double_ev, ev_neg);
endinterface

// [ptd_axis.sv]
// one-axis single/double pulse detector, advancing once per detection step
// assumes magnitude already rescaled to the 8 g basis and a one-cycle step enable
`timescale 1ns/100ps
module ptd_axis
    import ptd_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    ptd_axis_if.axis a
);
    ptd_state_t state_q;
    logic [7:0] cnt_q;
    logic above;
    logic first_neg_q;
    logic prev_above_q;

    ////////////////////////////////////////////////////////////////
    // compare against the programmed threshold scaled to milli-g
    assign above = a.mag > 14'(a.ths * PTD_THS_MG);

    // level seen at the previous step, so only a fresh crossing starts a pulse;
    // a rejected over-long pulse cannot restart while it stays high
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prev_above_q <= 1'b0;
        end else if (a.step) begin
            prev_above_q <= above;
        end
    end

    // pulse, latency and window sequencing
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= PTD_IDLE;
            cnt_q <= 8'h00;
            first_neg_q <= 1'b0;
            a.single_ev <= 1'b0;
            a.double_ev <= 1'b0;
            a.ev_neg <= 1'b0;
        end else begin
            a.single_ev <= 1'b0;
            a.double_ev <= 1'b0;
            if (a.step) begin
                unique case (state_q)
                    PTD_IDLE: begin
                        if (above && !prev_above_q) begin
                            state_q <= PTD_HIGH;
                            cnt_q <= 8'h00;
                            first_neg_q <= a.neg;
                        end
                    end
                    PTD_HIGH: begin
                        if (!above) begin
                            // a single pulse ends inside the limit
                            a.single_ev <= 1'b1;
                            a.ev_neg <= first_neg_q;
                            state_q <= PTD_LTCY;
                            cnt_q <= 8'h00;
                        end else if (cnt_q >= a.tmlt) begin
                            state_q <= PTD_IDLE;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    PTD_LTCY: begin
                        // with abort set a short pulse inside latency suspends the double tap
                        if (a.abort && above) begin
                            state_q <= PTD_IDLE;
                        end else if (cnt_q >= a.ltcy) begin
                            state_q <= PTD_WIND;
                            cnt_q <= 8'h00;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    PTD_WIND: begin
                        if (above) begin
                            a.double_ev <= 1'b1;
                            a.ev_neg <= a.neg;
                            state_q <= PTD_IDLE;
                        end else if (cnt_q >= a.wind) begin
                            state_q <= PTD_IDLE;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    // a high phase seen to end on a step
    sequence s_high_end;
        state_q == PTD_HIGH && a.step && !above;
    endsequence

    a_time_limit: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == PTD_HIGH |-> cnt_q <= a.tmlt)
        else $error("time limit counter beyond limit");
    a_single_end: assert property (@(posedge clock) disable iff (!reset_n)
        a.single_ev |-> $past(state_q) == PTD_HIGH)
        else $error("single pulse without prior high phase");
    a_single_emit: assert property (@(posedge clock) disable iff (!reset_n)
        s_high_end |=> a.single_ev)
        else $error("pulse ended inside limit without single event");
    a_fresh_cross: assert property (@(posedge clock) disable iff (!reset_n)
        (a.step && state_q == PTD_IDLE && prev_above_q) |=> state_q == PTD_IDLE)
        else $error("pulse started without a threshold crossing");
endmodule

// [ptd_top.sv]
// pulse/tap detection top: register file, time-step divider, three axes, status and irq
// assumes synchronous sample inputs, taken by each axis at every detection step with no sample strobe
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////
// Operation
// - abort clear: double detection continues despite new pulse in latency
// - abort set: pulse starting and ending in latency suspends double detection
// - latch set: event flags held until status read, read clears them
// - per-axis enable lets double pulse raise the event flag
// - per-axis enable lets single pulse raise the event flag
// - summary bit shows any pulse event generated
// - one event bit per axis
// - status bit tells single (0) or double (1) first trigger
// - per-axis polarity bit: 0 positive, 1 negative
// - detection starts when axis crosses its own threshold
// - thresholds are 7-bit unsigned, 0.063 g per count
// - thresholds always on 8 g basis whatever range selected
// - 8-bit limit bounds time above threshold for a pulse
// - longest limit is minimum step times 255
// - 400 Hz, normal, filter off: one count is 0.625 ms
module ptd_top
    import ptd_pkg::*;
#(
    parameter int STEP_CYC = PTD_STEP_CYC
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [41:0] accel_data,
    output logic irq
);
    logic [7:0] cfg_q;
    logic [6:0] ths_q [3];
    logic [7:0] tmlt_q;
    logic [7:0] ltcy_q;
    logic [7:0] wind_q;
    logic [7:0] mode_q;
    logic [7:0] stat_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_en_q;
    logic [16:0] div_q;
    logic [2:0] mult_q;
    logic [6:0] sub_q;
    logic step;
    logic [16:0] div_end;
    logic [2:0] single_ev;
    logic [2:0] double_ev;
    logic [2:0] ev_neg;
    logic [2:0] hit;
    logic any_hit;
    logic stat_read;
    logic [7:0] stat_new;

    ////////////////////////////////////////////////////////////////
    // register writes; the status register is read-only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cfg_q <= PTD_REG_RST;
            ths_q <= '{default: 7'h00};
            tmlt_q <= PTD_REG_RST;
            ltcy_q <= PTD_REG_RST;
            wind_q <= PTD_REG_RST;
            mode_q <= PTD_REG_RST;
            irq_en_q <= 2'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                PTD_CFG_ADDR: cfg_q <= reg_wdata;
                PTD_THX_ADDR: ths_q[0] <= reg_wdata[6:0];
                PTD_THY_ADDR: ths_q[1] <= reg_wdata[6:0];
                PTD_THZ_ADDR: ths_q[2] <= reg_wdata[6:0];
                PTD_TMLT_ADDR: tmlt_q <= reg_wdata;
                PTD_LTCY_ADDR: ltcy_q <= reg_wdata;
                PTD_WIND_ADDR: wind_q <= reg_wdata;
                PTD_MODE_ADDR: mode_q <= reg_wdata;
                PTD_IRQ_EN_ADDR: irq_en_q <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                PTD_CFG_ADDR: reg_rdata <= cfg_q;
                PTD_STAT_ADDR: reg_rdata <= stat_q;
                PTD_THX_ADDR: reg_rdata <= {1'b0, ths_q[0]};
                PTD_THY_ADDR: reg_rdata <= {1'b0, ths_q[1]};
                PTD_THZ_ADDR: reg_rdata <= {1'b0, ths_q[2]};
                PTD_TMLT_ADDR: reg_rdata <= tmlt_q;
                PTD_LTCY_ADDR: reg_rdata <= ltcy_q;
                PTD_WIND_ADDR: reg_rdata <= wind_q;
                PTD_MODE_ADDR: reg_rdata <= mode_q;
                PTD_IRQ_STAT_ADDR: reg_rdata <= {6'h00, irq_stat_q};
                PTD_IRQ_EN_ADDR: reg_rdata <= {6'h00, irq_en_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // time step: base 0.625 ms doubled per output rate halving, and
    // doubled again with the filter on, except at output rate code 7 where the 3-bit sum wraps to the base step; the limit then spans step * 255
    always_comb begin
        mult_q = mode_q[PTD_MODE_ODR_LSB +: 3] + {2'b00, mode_q[PTD_MODE_HPF]};
        // high-resolution oversampling ignores the output rate; only the filter still doubles the step
        if (mode_q[PTD_MODE_OSR_LSB +: 2] == 2'd2) begin
            mult_q = {2'b00, mode_q[PTD_MODE_HPF]};
        end
    end

    assign div_end = 17'(STEP_CYC - 1);

    // clock divider gives the base tick; a second stage scales it by 2^mult
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_q <= 17'h00000;
            sub_q <= 7'h00;
        end else if (div_q == div_end) begin
            div_q <= 17'h00000;
            sub_q <= sub_q + 7'h01;
        end else begin
            div_q <= div_q + 17'h00001;
        end
    end

    // the step fires once the sub-count's low bits match the scale; a
    // 7-bit sub-count limits the slowest step to 128 base ticks
    always_comb begin
        step = (div_q == div_end) && ((sub_q & 7'(((1 << mult_q) - 1))) == 7'h00);
    end

    ////////////////////////////////////////////////////////////////
    // three axes; the threshold basis is fixed at 8 g whatever range is set
    ptd_axis_if ax_if [3] ();
    for (genvar i = 0; i < 3; i++) begin : g_axis
        logic [13:0] raw;
        assign raw = accel_data[14*i +: 14];
        assign ax_if[i].step = step;
        assign ax_if[i].neg = raw[13];
        assign ax_if[i].mag = raw[13] ? 14'(-raw) : raw;
        assign ax_if[i].ths = ths_q[i];
        assign ax_if[i].tmlt = tmlt_q;
        assign ax_if[i].ltcy = ltcy_q;
        assign ax_if[i].wind = wind_q;
        assign ax_if[i].abort = cfg_q[PTD_CFG_ABORT];
        assign single_ev[i] = ax_if[i].single_ev;
        assign double_ev[i] = ax_if[i].double_ev;
        assign ev_neg[i] = ax_if[i].ev_neg;
        // enables gate each axis's single and double event
        assign hit[i] = (single_ev[i] && cfg_q[PTD_CFG_SPE_X + 2*i])
                     || (double_ev[i] && cfg_q[PTD_CFG_SPE_X + 2*i + 1]);
        ptd_axis u_axis (
            .clock(clock),
            .reset_n(reset_n),
            .a(ax_if[i])
        );
    end

    assign any_hit = |hit;
    assign stat_read = reg_read && (reg_addr == PTD_STAT_ADDR);

    ////////////////////////////////////////////////////////////////
    // status word built from this step's enabled events
    always_comb begin
        stat_new = stat_read ? 8'h00 : stat_q; // a read in the same cycle drops older flags
        stat_new[PTD_ST_EA] = 1'b1;
        stat_new[PTD_ST_DPE] = |(double_ev & hit);
        for (int j = 0; j < 3; j++) begin
            if (hit[j]) begin
                stat_new[PTD_ST_AX_LSB + j] = 1'b1;
                stat_new[PTD_ST_POL_LSB + j] = ev_neg[j];
            end
        end
    end

    // latched: first result held until read; unlatched: each result updates
    // flags; a read clears, but an event in the same cycle wins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stat_q <= 8'h00;
        end else if (any_hit && (!cfg_q[PTD_CFG_LATCH] || !stat_q[PTD_ST_EA] || stat_read)) begin
            stat_q <= stat_new;
        end else if (stat_read) begin
            stat_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt: bit0 single, bit1 double; write-one-to-clear, set wins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((reg_write && reg_addr == PTD_IRQ_CLR_ADDR)
                          ? reg_wdata[1:0] : 2'h0))
                          | {|(double_ev & hit), |(single_ev & hit)};
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    a_latch_hold: assert property (@(posedge clock) disable iff (!reset_n)
        (cfg_q[PTD_CFG_LATCH] && stat_q[PTD_ST_EA] && !stat_read) |=> $stable(stat_q))
        else $error("latched status changed without a read");
    a_read_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (stat_read && !any_hit) |=> stat_q == 8'h00)
        else $error("status not cleared by read");
    a_event_summary: assert property (@(posedge clock) disable iff (!reset_n)
        (stat_q[PTD_ST_AX_LSB +: 3] != 3'h0) |-> stat_q[PTD_ST_EA])
        else $error("axis flag without summary bit");
    a_axis_flag: assert property (@(posedge clock) disable iff (!reset_n)
        (hit[0] && !cfg_q[PTD_CFG_LATCH]) |=> stat_q[PTD_ST_AX_LSB])
        else $error("x event flag missing");
    a_double_kind: assert property (@(posedge clock) disable iff (!reset_n)
        (any_hit && !cfg_q[PTD_CFG_LATCH])
        |=> stat_q[PTD_ST_DPE] == $past(|(double_ev & hit)))
        else $error("double pulse kind wrong");
    a_single_gate: assert property (@(posedge clock) disable iff (!reset_n)
        (single_ev[0] && !cfg_q[PTD_CFG_SPE_X]) |-> !hit[0])
        else $error("disabled single event raised flag");
    a_double_gate: assert property (@(posedge clock) disable iff (!reset_n)
        (double_ev[1] && !cfg_q[PTD_CFG_SPE_X + 3]) |-> !hit[1])
        else $error("disabled double event raised flag");
    a_axis_polarity: assert property (@(posedge clock) disable iff (!reset_n)
        (hit[0] && !cfg_q[PTD_CFG_LATCH])
        |=> stat_q[PTD_ST_POL_LSB] == $past(ev_neg[0]))
        else $error("x polarity bit wrong");
    a_irq_level: assert property (@(posedge clock) disable iff (!reset_n)
        (|(single_ev & hit)) |=> irq_stat_q[0])
        else $error("single event did not set interrupt status");
    a_irq_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (reg_write && reg_addr == PTD_IRQ_CLR_ADDR && reg_wdata[0] && !(|(single_ev & hit)))
        |=> !irq_stat_q[0])
        else $error("interrupt status not cleared");
    a_rdata_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

// [ptd_host.sv]
// host-side model: software reaching the detector registers over the plain port
// assumes one clock shared with the detector; the slave never makes it wait
`timescale 1ns/100ps
module ptd_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    ////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // one-cycle write; address and data are scrambled afterwards so stale values never help
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // one-cycle read; data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        // the data stand until the next edge; take them there, before they drop to zero
        @(posedge clock);
        d = reg_rdata;
    endtask
endmodule

// [ptd_top_bench.sv]
// self-checking bench for the pulse/tap detector top
// assumes ptd_host drives the register port; samples are driven here
`timescale 1ns/100ps
module ptd_top_bench;
    import ptd_pkg::*;
    localparam int STEP = 4;
    localparam int TMLT = 10;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [41:0] accel_data = '0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, reg_read, irq;
    int fails = 0;
    int tests_run = 0;
    int ths;
    int amp;

    always #12.5 clock = ~clock;

    ptd_host host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    ptd_top #(.STEP_CYC(STEP)) uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .accel_data(accel_data), .irq(irq));

    ////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic end_sim();
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one axis above threshold for len cycles; step phase is unknown, so margins are wide
    task automatic pulse(input int ax, input int val, input int len);
        @(posedge clock);
        accel_data[14*ax +: 14] <= val[13:0];
        repeat (len) @(posedge clock);
        accel_data <= '0;
    endtask

    // second pulse lands inside the window, well clear of the latency
    task automatic twin(input int ax, input int val, input int dbl);
        pulse(ax, val, 12);
        if (dbl != 0) begin
            idle(40);
            pulse(ax, val, 12);
        end
    endtask

    // reference model of the status byte for one event
    function automatic logic [7:0] exp_st(input int ax, input bit dbl, input bit neg);
        logic [7:0] s;
        s = 8'h80 | (8'h10 << ax);
        s[PTD_ST_DPE] = dbl;
        s[PTD_ST_POL_LSB + ax] = neg;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(18880));
        idle(4);
        reset_n <= 1'b1;
        // reset values, unmapped holes included; the clear register is write-only
        for (int a = 'h20; a <= 'h30; a++) begin
            if (a != 'h2b) rd_chk(a[7:0], 8'h00);
        end
        check({7'h0, irq}, 8'h00);
        ths = 8 + $urandom % 40;
        amp = ths * 63 + 1 + $urandom % 400;
        host.wr(PTD_THX_ADDR, ths[7:0]);
        host.wr(PTD_THY_ADDR, ths[7:0]);
        host.wr(PTD_THZ_ADDR, ths[7:0]);
        host.wr(PTD_TMLT_ADDR, 8'(TMLT));
        host.wr(PTD_LTCY_ADDR, 8'h04);
        host.wr(PTD_WIND_ADDR, 8'h14);
        host.wr(PTD_STAT_ADDR, 8'hff);
        host.wr(8'h30, 8'h5a);
        rd_chk(PTD_THZ_ADDR, ths[7:0]);
        rd_chk(PTD_TMLT_ADDR, 8'(TMLT));
        rd_chk(PTD_STAT_ADDR, 8'h00);
        rd_chk(8'h30, 8'h00);
        // every axis and kind; the neighbouring, disabled axis must stay silent
        for (int ax = 0; ax < 3; ax++) begin
            for (int k = 0; k < 2; k++) begin
                host.wr(PTD_CFG_ADDR, 8'h40 | (8'h01 << (2 * ax + k)));
                twin((ax + 1) % 3, amp, k);
                idle(150);
                rd_chk(PTD_STAT_ADDR, 8'h00);
                twin(ax, ((ax + k) % 2 != 0) ? -amp : amp, k);
                idle(150);
                rd_chk(PTD_STAT_ADDR, exp_st(ax, k[0], 1'((ax + k) % 2)));
                rd_chk(PTD_STAT_ADDR, 8'h00);
            end
        end
        // exact threshold boundary with another range selected
        host.wr(PTD_MODE_ADDR, 8'h40);
        host.wr(PTD_CFG_ADDR, 8'h41);
        pulse(0, ths * 63, 12);
        idle(150);
        rd_chk(PTD_STAT_ADDR, 8'h00);
        pulse(0, ths * 63 + 1, 12);
        idle(150);
        rd_chk(PTD_STAT_ADDR, exp_st(0, 1'b0, 1'b0));
        host.wr(PTD_MODE_ADDR, 8'h00);
        // pulses too long, short enough, and the longest limit
        host.wr(PTD_CFG_ADDR, 8'h44);
        pulse(1, amp, (TMLT + 4) * STEP);
        idle(150);
        rd_chk(PTD_STAT_ADDR, 8'h00);
        pulse(1, amp, (TMLT - 3) * STEP);
        idle(150);
        rd_chk(PTD_STAT_ADDR, exp_st(1, 1'b0, 1'b0));
        host.wr(PTD_TMLT_ADDR, 8'hff);
        pulse(1, amp, 200 * STEP);
        idle(150);
        rd_chk(PTD_STAT_ADDR, exp_st(1, 1'b0, 1'b0));
        host.wr(PTD_TMLT_ADDR, 8'(TMLT));
        // short pulse inside a long latency, then one in the window
        host.wr(PTD_LTCY_ADDR, 8'h14);
        host.wr(PTD_WIND_ADDR, 8'h1e);
        for (int ab = 0; ab < 2; ab++) begin
            host.wr(PTD_CFG_ADDR, (ab != 0) ? 8'hc2 : 8'h42);
            pulse(0, amp, 12);
            idle(20);
            pulse(0, amp, 8);
            idle(80);
            pulse(0, amp, 12);
            idle(250);
            rd_chk(PTD_STAT_ADDR, (ab != 0) ? 8'h00 : exp_st(0, 1'b1, 1'b0));
        end
        host.wr(PTD_LTCY_ADDR, 8'h04);
        host.wr(PTD_WIND_ADDR, 8'h14);
        // positive then negative event, unlatched and latched
        for (int lt = 0; lt < 2; lt++) begin
            host.wr(PTD_CFG_ADDR, (lt != 0) ? 8'h41 : 8'h01);
            pulse(0, amp, 12);
            idle(150);
            pulse(0, -amp, 12);
            idle(150);
            rd_chk(PTD_STAT_ADDR, exp_st(0, 1'b0, lt == 0));
        end
        // interrupt: raised while masked, write-one clear of the other bit, unmask, clear
        host.wr(PTD_IRQ_CLR_ADDR, 8'h03);
        host.wr(PTD_IRQ_EN_ADDR, 8'h00);
        host.wr(PTD_CFG_ADDR, 8'h50);
        pulse(2, amp, 12);
        idle(150);
        check({7'h0, irq}, 8'h00);
        rd_chk(PTD_IRQ_STAT_ADDR, 8'h01);
        host.wr(PTD_IRQ_CLR_ADDR, 8'h02);
        rd_chk(PTD_IRQ_STAT_ADDR, 8'h01);
        host.wr(PTD_IRQ_EN_ADDR, 8'h01);
        idle(2);
        check({7'h0, irq}, 8'h01);
        host.wr(PTD_IRQ_CLR_ADDR, 8'h01);
        idle(2);
        check({7'h0, irq}, 8'h00);
        rd_chk(PTD_IRQ_STAT_ADDR, 8'h00);
        end_sim();
    end

    // watchdog, generous against roughly six thousand expected cycles
    initial begin
        idle(40000);
        fails++;
        end_sim();
    end
endmodule
